/* hw/cmp_ref_pkg.sv */
package cmp_ref_pkg;

   // System clock
   localparam int unsigned CLK_MHZ = 25;
   localparam int unsigned NS_PER_US = 1000;

   // APB geometry
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned REG_W = 8;
   localparam logic [11:0] CTRL_OFFS = 12'h000;
   localparam logic [11:0] STATUS_OFFS = 12'h004;
   localparam logic [7:0] CTRL_RESET = 8'h00;

   // Status word bit positions
   localparam int unsigned STAT_FIXED_ON = 0;
   localparam int unsigned STAT_FIXED_READY = 1;
   localparam int unsigned STAT_LADDER_ON = 2;
   localparam int unsigned STAT_OSC_ACTIVE = 3;
   localparam int unsigned STAT_CLAMPED = 4;

   // Ladder ratios, all over a common denominator of 96
   localparam int unsigned TAP_W = 4;
   localparam int unsigned RATIO_W = 7;
   localparam logic [6:0] RATIO_DEN = 7'h60;
   localparam logic [6:0] LOW_STEP = 7'h04;
   localparam logic [6:0] HIGH_BASE = 7'h18;
   localparam logic [6:0] HIGH_STEP = 7'h03;

   // Fixed reference settling, default only; electrical limit governs
   localparam int unsigned SETTLE_NS = 10000;

   // Control register layout, bit 7 down to bit 0
   typedef struct packed {
      logic cmp1_sel;
      logic cmp2_sel;
      logic range_low;
      logic fixed_en;
      logic [3:0] tap;
   } ref_fields_t;

   // Drive towards the analog ladder
   typedef struct packed {
      logic current_on;
      logic clamp_gnd;
      logic range_low;
      logic [3:0] tap;
      logic [6:0] ratio_num;
   } ladder_ctl_t;

   typedef enum logic [1:0] {
      FIX_OFF = 2'b00,
      FIX_SETTLING = 2'b01,
      FIX_READY = 2'b10
   } fix_state_t;

endpackage

/* hw/comparator_reference_control.sv */
`timescale 1ns/100ps
// Behaviour
// (RULE_01) Ladder disabled, low range, code zero: output at ground, no ladder current.
// (RULE_02) Fixed reference enable bit 4 turns the 0.6 V reference on or off.
// (RULE_03) Fixed reference stays on while the fast internal oscillator runs.
// (RULE_04) Software waits a settling delay after enabling the fixed reference.
// (RULE_05) Bit 7 powers ladder and routes it to comparator 1, else fixed.
// (RULE_06) Bit 6 powers ladder and routes it to comparator 2, else fixed.
// (RULE_07) Both select bits zero cut ladder divider current.
// (RULE_08) Bit 5 one selects low range, zero selects high range.
// (RULE_09) Tap code: low range code/24, high range 1/4 plus code/32 of supply.
// (RULE_10) Writes update fields and derived outputs at next edge; reset clears all. Derived outputs here lag the fields by one edge.
module comparator_reference_control #(
   parameter int unsigned SETTLE_NS = cmp_ref_pkg::SETTLE_NS
) (
   input wire logic clk, // System clock, 25 MHz
   input wire logic nrst, // Asynchronous reset, active low
   input wire logic psel, // APB select
   input wire logic penable, // APB access phase
   input wire logic pwrite, // APB direction, high for write
   input wire logic [11:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   input wire logic [3:0] pstrb, // APB write byte strobes
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB transfer done
   output logic pslverr, // APB error, unmapped address
   input wire logic ladder_enable, // Ladder enable, same clock domain
   input wire logic fast_osc_active, // Fast internal oscillator running
   output cmp_ref_pkg::ladder_ctl_t ladder_ctl, // Drive to the ladder
   output logic cmp1_ref_from_ladder, // Comparator 1 takes ladder
   output logic cmp2_ref_from_ladder, // Comparator 2 takes ladder
   output logic fixed_ref_on, // Fixed 0.6 V reference powered
   output logic fixed_ref_ready // Fixed reference past settling time
);
   localparam int unsigned SETTLE_CYC_RAW =
      (SETTLE_NS * cmp_ref_pkg::CLK_MHZ + cmp_ref_pkg::NS_PER_US - 1)
      / cmp_ref_pkg::NS_PER_US;
   localparam int unsigned SETTLE_CYC =
      (SETTLE_CYC_RAW < 1) ? 1 : SETTLE_CYC_RAW;
   localparam int unsigned CNT_W = $clog2(SETTLE_CYC + 1);
   localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(SETTLE_CYC - 1);

   cmp_ref_pkg::ref_fields_t fields_q;
   cmp_ref_pkg::ladder_ctl_t ladder_ctl_d;
   cmp_ref_pkg::fix_state_t fix_state_q;
   cmp_ref_pkg::fix_state_t fix_state_d;
   logic osc_meta_q;
   logic osc_sync_q;
   logic fixed_on_d;
   logic [CNT_W-1:0] settle_cnt_q;
   logic access;
   logic hit_ctrl;
   logic hit_status;
   logic wr_ctrl;
   logic [31:0] status_word;
   logic [31:0] rdata_d;

   // APB decode
   assign access = psel & penable;
   assign hit_ctrl = (paddr == cmp_ref_pkg::CTRL_OFFS);
   assign hit_status = (paddr == cmp_ref_pkg::STATUS_OFFS);
   // Write lands on the edge where the master sees pready high
   assign wr_ctrl = access & pready & pwrite & hit_ctrl & pstrb[0];

   // Oscillator flag comes from another clock domain
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         osc_meta_q <= 1'b0;
         osc_sync_q <= 1'b0;
      end else begin
         osc_meta_q <= fast_osc_active;
         osc_sync_q <= osc_meta_q;
      end
   end

   // Control register
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         fields_q <= cmp_ref_pkg::CTRL_RESET; // [RULE_10]
      end else if (wr_ctrl) begin
         fields_q <= pwdata[cmp_ref_pkg::REG_W-1:0]; // [RULE_10] [RULE_02]
      end
   end

   ladder_ctrl u_ladder (
      .fields(fields_q),
      .ladder_enable(ladder_enable),
      .ctl(ladder_ctl_d)
   );

   assign fixed_on_d = fields_q.fixed_en | osc_sync_q; // [RULE_02] [RULE_03]

   // Registered analog drive
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ladder_ctl <= '0; // [RULE_10]
         cmp1_ref_from_ladder <= 1'b0;
         cmp2_ref_from_ladder <= 1'b0;
         fixed_ref_on <= 1'b0;
      end else begin
         ladder_ctl <= ladder_ctl_d; // [RULE_10]
         cmp1_ref_from_ladder <= fields_q.cmp1_sel; // [RULE_05]
         cmp2_ref_from_ladder <= fields_q.cmp2_sel; // [RULE_06]
         fixed_ref_on <= fixed_on_d; // [RULE_02] [RULE_03]
      end
   end

   // Settling tracker, a software aid; it does not gate the reference
   always_comb begin
      fix_state_d = fix_state_q;
      unique case (fix_state_q)
         cmp_ref_pkg::FIX_OFF: begin
            if (fixed_on_d) begin
               fix_state_d = cmp_ref_pkg::FIX_SETTLING;
            end
         end
         cmp_ref_pkg::FIX_SETTLING: begin
            if (!fixed_on_d) begin
               fix_state_d = cmp_ref_pkg::FIX_OFF;
            end else if (settle_cnt_q == SETTLE_LAST) begin
               fix_state_d = cmp_ref_pkg::FIX_READY; // [RULE_04]
            end
         end
         cmp_ref_pkg::FIX_READY: begin
            if (!fixed_on_d) begin
               fix_state_d = cmp_ref_pkg::FIX_OFF;
            end
         end
         default: begin
            fix_state_d = cmp_ref_pkg::FIX_OFF;
         end
      endcase
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         fix_state_q <= cmp_ref_pkg::FIX_OFF;
      end else begin
         fix_state_q <= fix_state_d;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         settle_cnt_q <= '0;
      end else if (fix_state_q == cmp_ref_pkg::FIX_SETTLING) begin
         settle_cnt_q <= settle_cnt_q + 1'b1; // [RULE_04]
      end else begin
         settle_cnt_q <= '0;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         fixed_ref_ready <= 1'b0;
      end else begin
         fixed_ref_ready <= (fix_state_d == cmp_ref_pkg::FIX_READY); // [RULE_04]
      end
   end

   // Status word shows live drive state
   always_comb begin
      status_word = '0;
      status_word[cmp_ref_pkg::STAT_FIXED_ON] = fixed_ref_on;
      status_word[cmp_ref_pkg::STAT_FIXED_READY] = fixed_ref_ready;
      status_word[cmp_ref_pkg::STAT_LADDER_ON] = ladder_ctl.current_on;
      status_word[cmp_ref_pkg::STAT_OSC_ACTIVE] = osc_sync_q;
      status_word[cmp_ref_pkg::STAT_CLAMPED] = ladder_ctl.clamp_gnd;
   end

   always_comb begin
      rdata_d = '0;
      if (hit_ctrl) begin
         rdata_d = {24'h000000, fields_q};
      end else if (hit_status) begin
         rdata_d = status_word;
      end
   end

   // One wait state keeps every bus output on a flop
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= '0;
      end else if (access & !pready) begin
         pready <= 1'b1;
         pslverr <= ~(hit_ctrl | hit_status);
         prdata <= pwrite ? 32'h00000000 : rdata_d;
      end else begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= '0;
      end
   end
endmodule // comparator_reference_control

/* hw/ladder_ctrl.sv */
`timescale 1ns/100ps
module ladder_ctrl (
   input wire cmp_ref_pkg::ref_fields_t fields, // Stored control fields
   input wire logic ladder_enable, // Ladder enable from its own register
   output cmp_ref_pkg::ladder_ctl_t ctl // Unregistered ladder drive
);
   logic [6:0] tap_w;
   logic [6:0] low_num;
   logic [6:0] high_num;

   assign tap_w = {3'h0, fields.tap};
   assign low_num = 7'(tap_w * cmp_ref_pkg::LOW_STEP); // [RULE_09]
   assign high_num = 7'(cmp_ref_pkg::HIGH_BASE
                        + tap_w * cmp_ref_pkg::HIGH_STEP); // [RULE_09]

   always_comb begin
      ctl.range_low = fields.range_low; // [RULE_08]
      ctl.tap = fields.tap; // [RULE_09]
      // Divider draws current only if some comparator uses it
      ctl.current_on = ladder_enable
                       & (fields.cmp1_sel | fields.cmp2_sel); // [RULE_05] [RULE_06] [RULE_07] [RULE_01]
      // Disabled ladder parks its output on ground
      ctl.clamp_gnd = ~ladder_enable; // [RULE_01]
      if (!ladder_enable) begin
         ctl.ratio_num = 7'h00; // [RULE_01]
      end else if (fields.range_low) begin
         ctl.ratio_num = low_num; // [RULE_08]
      end else begin
         ctl.ratio_num = high_num; // [RULE_08]
      end
   end
endmodule // ladder_ctrl

/* testbench/comparator_reference_control_tb.sv */
`timescale 1ns/100ps
module comparator_reference_control_tb;
   logic clk = 1'h0;
   logic nrst = 1'h0;
   logic psel = 1'h0;
   logic penable = 1'h0;
   logic pwrite = 1'h0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] pstrb = 4'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic ladder_enable = 1'h1;
   logic fast_osc_active = 1'h0;
   cmp_ref_pkg::ladder_ctl_t ladder_ctl;
   logic cmp1_ref_from_ladder;
   logic cmp2_ref_from_ladder;
   logic fixed_ref_on;
   logic fixed_ref_ready;
   logic [31:0] rd;
   logic er;
   int failures = 0;
   int n_checks = 0;
   int cycles = 0;
   // Short settle count keeps the ready wait to a few cycles
   comparator_reference_control #(.SETTLE_NS(80)) DUT (.clk, .nrst, .psel,
      .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
      .ladder_enable, .fast_osc_active, .ladder_ctl, .cmp1_ref_from_ladder,
      .cmp2_ref_from_ladder, .fixed_ref_on, .fixed_ref_ready);
   task automatic conclude;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input logic ok);
      n_checks++;
      if (ok !== 1'h1) begin
         failures++;
         $display("wrong value at %0t: output mismatch", $time);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d, input logic [3:0] s);
      @(posedge clk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge clk);
      penable <= 1'h1;
      @(posedge clk);
      // Ends when pready goes high; the bench timeout catches a wait that never ends
      while (pready !== 1'h1) begin
         @(posedge clk);
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic wr(input logic [7:0] v);
      apb(1'h1, cmp_ref_pkg::CTRL_OFFS, {24'h0, v}, 4'h1);
      repeat (2) @(negedge clk);
   endtask
   task automatic t_reset;
      wr(8'hff);
      @(posedge clk);
      nrst <= 1'h0;
      @(posedge clk);
      nrst <= 1'h1;
      apb(1'h0, cmp_ref_pkg::CTRL_OFFS, 32'h0, 4'h0);
      chk(rd === 32'h0);
      chk(cmp1_ref_from_ladder === 1'h0);
      chk(fixed_ref_on === 1'h0);
      $display("reset done");
   endtask
   task automatic t_modes;
      logic [7:0] v [5] = '{8'hff, 8'h2f, 8'h8a, 8'h40, 8'h00};
      logic [6:0] x;
      foreach (v[i]) begin
         wr(v[i]);
         x = v[i][5] ? 7'(v[i][3:0]) * cmp_ref_pkg::LOW_STEP
            : cmp_ref_pkg::HIGH_BASE + 7'(v[i][3:0]) * cmp_ref_pkg::HIGH_STEP;
         chk(ladder_ctl.ratio_num === x);
         chk(ladder_ctl.tap === v[i][3:0]);
         chk(ladder_ctl.range_low === v[i][5]);
         chk(cmp1_ref_from_ladder === v[i][7]);
         chk(cmp2_ref_from_ladder === v[i][6]);
         chk(ladder_ctl.current_on === (v[i][7] | v[i][6]));
         apb(1'h0, cmp_ref_pkg::CTRL_OFFS, 32'h0, 4'h0);
         chk(rd === {24'h0, v[i]});
      end
      $display("modes done");
   endtask
   task automatic t_clamp;
      @(posedge clk);
      ladder_enable <= 1'h0;
      // Select bit set so that only the disabled ladder keeps current off
      wr(8'ha0);
      chk(ladder_ctl.clamp_gnd === 1'h1);
      chk(ladder_ctl.ratio_num === 7'h00);
      chk(ladder_ctl.current_on === 1'h0);
      $display("clamp done");
   endtask
   task automatic t_fixed;
      logic [31:0] s;
      wr(8'h10);
      chk(fixed_ref_on === 1'h1);
      chk(fixed_ref_ready === 1'h0);
      repeat (10) if (fixed_ref_ready !== 1'h1) @(negedge clk);
      chk(fixed_ref_ready === 1'h1);
      // Ladder still disabled from the clamp test
      s = '0;
      s[cmp_ref_pkg::STAT_FIXED_ON] = 1'h1;
      s[cmp_ref_pkg::STAT_FIXED_READY] = 1'h1;
      s[cmp_ref_pkg::STAT_CLAMPED] = 1'h1;
      apb(1'h0, cmp_ref_pkg::STATUS_OFFS, 32'h0, 4'h0);
      chk(rd === s);
      wr(8'h00);
      chk(fixed_ref_on === 1'h0);
      chk(fixed_ref_ready === 1'h0);
      @(posedge clk);
      fast_osc_active <= 1'h1;
      repeat (4) @(negedge clk);
      chk(fixed_ref_on === 1'h1);
      @(posedge clk);
      fast_osc_active <= 1'h0;
      $display("fixed done");
   endtask
   task automatic t_refuse;
      apb(1'h1, 12'h008, 32'hff, 4'hf);
      chk(er === 1'h1);
      apb(1'h1, cmp_ref_pkg::CTRL_OFFS, 32'hff, 4'h0);
      apb(1'h1, cmp_ref_pkg::STATUS_OFFS, 32'hff, 4'hf);
      chk(er === 1'h0);
      apb(1'h0, cmp_ref_pkg::CTRL_OFFS, 32'h0, 4'h0);
      chk(rd === 32'h0);
      $display("refuse done");
   endtask
   initial begin
      forever #20 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 2000) begin
         failures++;
         conclude();
      end
   end
   initial begin
      repeat (2) @(posedge clk);
      nrst <= 1'h1;
      t_reset();
      t_modes();
      t_clamp();
      t_fixed();
      t_refuse();
      conclude();
   end
endmodule // comparator_reference_control_tb

/* testbench/cref_props_properties.sv */
`timescale 1ns/100ps
module cref_props (
   input wire logic clk,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic ladder_enable,
   input wire logic fast_osc_active,
   input wire cmp_ref_pkg::ladder_ctl_t ladder_ctl,
   input wire logic cmp1_ref_from_ladder,
   input wire logic cmp2_ref_from_ladder,
   input wire logic fixed_ref_on
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   logic wr;
   assign wr = psel & penable & pready & pwrite & pstrb[0]
      & (paddr == cmp_ref_pkg::CTRL_OFFS);
   a_one_wait: assert property (psel && penable && !pready |=> pready)
      else $error("pready late");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready held");
   a_bad_addr: assert property (pready |-> pslverr ==
      (paddr != cmp_ref_pkg::CTRL_OFFS && paddr != cmp_ref_pkg::STATUS_OFFS))
      else $error("pslverr wrong");
   a_sel1_route: assert property (
      wr |-> ##2 cmp1_ref_from_ladder == $past(pwdata[7], 2))
      else $error("cmp1 select wrong");
   a_sel2_route: assert property (
      wr |-> ##2 cmp2_ref_from_ladder == $past(pwdata[6], 2))
      else $error("cmp2 select wrong");
   a_range_copy: assert property (wr |-> ##2
      ladder_ctl.range_low == $past(pwdata[5], 2)
      && ladder_ctl.tap == $past(pwdata[3:0], 2))
      else $error("range or tap wrong");
   // Two edges of margin: outputs stay zero just after release
   a_ratio_calc: assert property (
      $past(nrst) && $past(nrst, 2) |-> ladder_ctl.ratio_num ==
      (ladder_ctl.clamp_gnd ? 7'h00 : ladder_ctl.range_low ?
      {ladder_ctl.tap, 2'h0} : 7'h18 + 7'(ladder_ctl.tap) * 7'h03))
      else $error("ratio wrong");
   a_current_gate: assert property (
      $past(nrst) && $past(nrst, 2) |-> ladder_ctl.current_on ==
      (!ladder_ctl.clamp_gnd && (cmp1_ref_from_ladder || cmp2_ref_from_ladder)))
      else $error("ladder current wrong");
   a_clamp_follow: assert property (
      $past(nrst) && $past(nrst, 2) |->
      ladder_ctl.clamp_gnd == !$past(ladder_enable))
      else $error("clamp wrong");
   a_fixed_enable: assert property (
      !fast_osc_active [*4] ##0 wr |-> ##2 fixed_ref_on == $past(pwdata[4], 2))
      else $error("fixed enable wrong");
   a_osc_force: assert property (
      fast_osc_active [*4] |-> fixed_ref_on)
      else $error("oscillator override missing");
   c_write: cover property (wr);
   c_osc: cover property (fast_osc_active [*4]);
   c_err: cover property (pready && pslverr);
endmodule // cref_props
bind comparator_reference_control cref_props u_props (.clk, .nrst, .psel,
   .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready, .pslverr,
   .ladder_enable, .fast_osc_active, .ladder_ctl, .cmp1_ref_from_ladder,
   .cmp2_ref_from_ladder, .fixed_ref_on);
